// File: rtl/plm_pkg.sv
/*
   Package for the line maintenance block: register indices, field positions, reset values,
   timing constants and the packed structs that carry the APB request and the block state.
   Assumes a 100 MHz system clock and APB with 32-bit data.
*/
package plm_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_PATTERN_CONTROL = 6'h0d;
   localparam logic [5:0] IDX_LOOPBACK_CONTROL = 6'h0e;
   localparam logic [5:0] IDX_LOOP_CODE_LENGTHS = 6'h0f;
   localparam logic [5:0] IDX_TX_LOOP_CODE = 6'h10;
   localparam logic [5:0] IDX_RX_ACTIVATE_CODE = 6'h11;
   localparam logic [5:0] IDX_RX_DEACTIVATE_CODE = 6'h12;
   localparam logic [5:0] IDX_ERROR_COUNT_CONTROL = 6'h13;
   localparam logic [5:0] IDX_INTERRUPT_MASK_A = 6'h14;
   localparam logic [5:0] IDX_INTERRUPT_EDGE_SELECT = 6'h16;
   localparam logic [5:0] IDX_LINE_STATUS_A = 6'h17;
   localparam logic [5:0] IDX_LINE_STATUS_B = 6'h18;
   localparam logic [5:0] IDX_INTERRUPT_FLAGS_A = 6'h19;
   localparam logic [5:0] IDX_LINE_MODE = 6'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_PATTERN_CLOCK_SELECT = 2;
   localparam int POS_SEQUENCE_INVERT = 3;
   localparam int POS_ANALOG_LOOP = 0;
   localparam int POS_DIGITAL_LOOP = 1;
   localparam int POS_REMOTE_LOOP = 2;
   localparam int POS_AUTO_REMOTE_LOOP = 3;
   localparam int POS_E1_MODE = 0;
   // Flag, mask, edge-select and status bits share one layout
   localparam int POS_SEQ_SYNC = 0;
   localparam int POS_ACTIVATE = 1;
   localparam int POS_DEACTIVATE = 2;

   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] PATT_NORMAL = 2'h0;
   localparam logic [1:0] PATT_ALL_ONES = 2'h1;
   localparam logic [1:0] PATT_SEQUENCE = 2'h2;
   localparam logic [1:0] PATT_LOOP_CODE = 2'h3;
   localparam logic [1:0] LOOP_PINS_DIGITAL = 2'h2;
   localparam logic [1:0] LOOP_PINS_REMOTE = 2'h3;
   localparam logic [1:0] ERR_SEL_SEQUENCE = 2'h0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [19:0] SEQ_SEED = 20'h00001;
   localparam int CODE_MIN_LENGTH = 5;

   // ----------------------------------------------------------------
   // Checker and detector thresholds
   // ----------------------------------------------------------------
   localparam logic [5:0] WINDOW_LAST = 6'h3f;
   localparam logic [6:0] SYNC_MAX_ERRORS = 7'h06;
   localparam logic [6:0] CODE_MIN_HITS = 7'h30;

   // ----------------------------------------------------------------
   // Times and derived cycle counts
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_KHZ = 100000;
   localparam int unsigned PERSIST_E1_MS = 30;
   localparam int unsigned PERSIST_T1_MS = 40;
   localparam int unsigned AUTO_LOOP_MS = 5100;
   localparam int unsigned PERSIST_E1_CYCLES = PERSIST_E1_MS * CLOCK_KHZ;
   localparam int unsigned PERSIST_T1_CYCLES = PERSIST_T1_MS * CLOCK_KHZ;
   localparam int unsigned AUTO_LOOP_CYCLES = AUTO_LOOP_MS * CLOCK_KHZ;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } plm_apb_req_s;

   typedef struct packed {
      logic [7:0] patternControl, loopControl, codeLengths, txCode, actCode, deactCode;
      logic [7:0] errControl, irqMask, edgeSel, lineMode;
      logic [2:0] irqFlags;
      logic [4:0] pinMeta, pinSync;
      logic [19:0] seqGen, seqChk;
      logic [5:0] winBits;
      logic [6:0] winErr;
      logic seqSync;
      logic [2:0] txCodeIdx;
      logic [7:0] rxHist;
      logic [5:0] codeBits;
      logic [1:0][6:0] hits;
      logic [1:0][29:0] timer;
      logic [1:0] present, seen;
      logic autoRemote;
      logic txBit, txValid, rxBit, rxValid, errorPulse, irq;
      logic analogLoop, digitalLoop, remoteLoop;
      logic [7:0] rdata;
      logic ready, slvErr;
   } plm_state_s;

endpackage : plm_pkg

// File: rtl/plm_maint.sv
/*
   Line maintenance block: test sequence generator and checker, loopback path selection,
   in-band loop code send and detect with automatic remote loopback, and APB registers.
   Assumes bit ticks and stream bits arrive on the system clock; mode pins are asynchronous.
*/
`timescale 1ns/1ns

// Behaviour
// - Sequence is 2^20-1 zero-restricted in T1/J1 and 2^15-1 in E1.
// - Pattern select 10 sends the test sequence MSB first instead of data.
// - Inversion bit sends the sequence true or inverted.
// - Sync set at 6 or fewer errors per 64-bit window, cleared above.
// - Edge select picks rising-only or any change of sync into its flag.
// - Interrupt while sync flag is set and its mask bit is 1.
// - Error select 00 forwards each checker error to the error counter.
// - Analog loop returns transmit bits to receive outputs, line still driven.
// - Internal patterns may override transmit data during local loops.
// - Digital loop returns transmit bits to receive outputs, line still driven.
// - Hardware mode: loop pins 10 digital, 11 remote loopback.
// - Remote loop sends recovered receive bits out on the line.
// - Pattern select 11 repeats the unframed loop code instead of data.
// - Receiver finds framed or unframed codes despite 1e-2 bit errors.
// - Sent code comes from an 8-bit pattern, length 5 to 8 bits.
// - Code sending stops with clock select 0 and pattern select 00.
// - Activate and deactivate codes each have own pattern and length.
// - Seen status set after code persists 30 ms E1, 40 ms T1/J1.
// - Code edge select 0 rising only, 1 any change; flags clear on read.
// - Auto mode: activate over 5.1 s sets and holds remote loopback.
// - Auto mode: deactivate over 5.1 s releases remote loopback.
// - Clearing auto enable releases automatic remote loopback at once.
// - Patterns use transmit clock tick, or master tick when select is 1.
module plm_maint #(
   parameter int unsigned PERSIST_E1_CYCLES = plm_pkg::PERSIST_E1_CYCLES,
   parameter int unsigned PERSIST_T1_CYCLES = plm_pkg::PERSIST_T1_CYCLES,
   parameter int unsigned AUTO_LOOP_CYCLES = plm_pkg::AUTO_LOOP_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Hardware control pins (asynchronous)
   input wire logic hardwareMode,
   input wire logic [1:0] patternSelectPins,
   input wire logic [1:0] loopSelectPins,
   // Bit ticks
   input wire logic transmitClockTick,
   input wire logic masterClockTick,
   // Transmit stream from system and to line
   input wire logic txDataIn,
   output logic txLineBit,
   output logic txLineValid,
   // Receive stream from line and to system
   input wire logic rxLineBit,
   input wire logic rxLineTick,
   output logic rxDataOut,
   output logic rxDataValid,
   // Loop state, error feed, interrupt
   output logic analogLoopActive,
   output logic digitalLoopActive,
   output logic remoteLoopActive,
   output logic sequenceErrorPulse,
   output logic interruptOut
);

   plm_pkg::plm_state_s s_ff, nxt_s;
   plm_pkg::plm_apb_req_s req;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // True when the newest-first history is any rotation of the code
   function automatic logic codeMatch(input logic [7:0] hist, input logic [7:0] pat, input logic [1:0] lenSel);
      int len;
      int idx;
      logic ok;
      logic any;
      len = plm_pkg::CODE_MIN_LENGTH + int'(lenSel);
      any = 1'b0;
      for (int r = 0; r < 8; r++)
      begin
         ok = (r < len);
         for (int i = 0; i < 8; i++)
         begin
            idx = i + r;
            if (idx >= len)
               idx = idx - len;
            if (i < len && hist[i] != pat[idx[2:0]])
               ok = 1'b0;
         end
         any = any | ok;
      end
      return any;
   endfunction : codeMatch

   function automatic logic seqFeedback(input logic [19:0] sr, input logic e1);
      return e1 ? (sr[14] ^ sr[13]) : (sr[19] ^ sr[16]);
   endfunction : seqFeedback

   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   logic [1:0] pattSel, codeLen;
   logic e1Mode, pattClkSel, invert, patTick, patternActive, loopLocal, remoteNow;
   logic genOut, lineBit, lineTick, rxSrcBit, rxSrcTick, chkBit, chkErr, winEnd, accDone, rdFlags;
   logic [2:0] evt, status, prevStatus;
   logic [5:0] regIdx;
   logic [29:0] persistCycles, autoCycles;
   logic [1:0] match, longDone;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      // Mode pins pass two flops before use
      nxt_s.pinMeta = {hardwareMode, patternSelectPins, loopSelectPins};
      nxt_s.pinSync = s_ff.pinMeta;
      e1Mode = s_ff.lineMode[plm_pkg::POS_E1_MODE];
      invert = s_ff.patternControl[plm_pkg::POS_SEQUENCE_INVERT];
      pattClkSel = s_ff.patternControl[plm_pkg::POS_PATTERN_CLOCK_SELECT];
      pattSel = s_ff.pinSync[4] ? s_ff.pinSync[3:2] : s_ff.patternControl[1:0];
      codeLen = s_ff.codeLengths[1:0];
      persistCycles = e1Mode ? 30'(PERSIST_E1_CYCLES) : 30'(PERSIST_T1_CYCLES);
      autoCycles = 30'(AUTO_LOOP_CYCLES);

      // Loop selection: register bits, or pins in hardware mode
      nxt_s.analogLoop = s_ff.loopControl[plm_pkg::POS_ANALOG_LOOP] & ~s_ff.pinSync[4];
      nxt_s.digitalLoop = s_ff.pinSync[4] ? (s_ff.pinSync[1:0] == plm_pkg::LOOP_PINS_DIGITAL)
                                          : s_ff.loopControl[plm_pkg::POS_DIGITAL_LOOP];
      remoteNow = s_ff.pinSync[4] ? (s_ff.pinSync[1:0] == plm_pkg::LOOP_PINS_REMOTE)
                                  : (s_ff.loopControl[plm_pkg::POS_REMOTE_LOOP] | s_ff.autoRemote);
      nxt_s.remoteLoop = remoteNow;
      loopLocal = s_ff.analogLoop | s_ff.digitalLoop;

      // Internal pattern source and its tick
      patTick = pattClkSel ? masterClockTick : transmitClockTick;
      patternActive = (pattSel != plm_pkg::PATT_NORMAL) | pattClkSel;
      genOut = seqFeedback(s_ff.seqGen, e1Mode);
      // Long zero runs forced to one in the T1 sequence
      if (!e1Mode && s_ff.seqGen[13:0] == 14'h0000)
         genOut = 1'b1;
      if (patTick && pattSel == plm_pkg::PATT_SEQUENCE)
         nxt_s.seqGen = (s_ff.seqGen == 20'h00000) ? plm_pkg::SEQ_SEED
                        : {s_ff.seqGen[18:0], seqFeedback(s_ff.seqGen, e1Mode)};
      if (pattSel != plm_pkg::PATT_LOOP_CODE)
         nxt_s.txCodeIdx = 3'h0;
      else if (patTick)
         nxt_s.txCodeIdx = (s_ff.txCodeIdx == 3'(plm_pkg::CODE_MIN_LENGTH - 1) + {1'b0, codeLen})
                           ? 3'h0 : s_ff.txCodeIdx + 3'h1;

      // Line side transmit selection
      if (remoteNow)
      begin
         lineBit = rxLineBit;
         lineTick = rxLineTick;
      end
      else if (patternActive)
      begin
         lineTick = patTick;
         case (pattSel)
            plm_pkg::PATT_ALL_ONES: lineBit = 1'b1;
            plm_pkg::PATT_SEQUENCE: lineBit = genOut ^ invert;
            plm_pkg::PATT_LOOP_CODE: lineBit = s_ff.txCode[3'(plm_pkg::CODE_MIN_LENGTH - 1) + {1'b0, codeLen}
                                                         - s_ff.txCodeIdx];
            default: lineBit = 1'b0;
         endcase
      end
      else
      begin
         lineBit = txDataIn;
         lineTick = transmitClockTick;
      end
      nxt_s.txBit = lineBit;
      nxt_s.txValid = lineTick;

      // Receive side: local loops take the transmitted bits, line still driven
      rxSrcBit = (s_ff.analogLoop | s_ff.digitalLoop) ? lineBit : rxLineBit;
      rxSrcTick = (s_ff.analogLoop | s_ff.digitalLoop) ? lineTick : rxLineTick;
      nxt_s.rxBit = rxSrcBit;
      nxt_s.rxValid = rxSrcTick;

      // Self-synchronising checker and hopping window
      chkBit = rxSrcBit ^ invert;
      chkErr = rxSrcTick && (chkBit != seqFeedback(s_ff.seqChk, e1Mode));
      winEnd = rxSrcTick && s_ff.winBits == plm_pkg::WINDOW_LAST;
      if (rxSrcTick)
      begin
         nxt_s.seqChk = {s_ff.seqChk[18:0], chkBit};
         nxt_s.winBits = s_ff.winBits + 6'h01;
         nxt_s.winErr = winEnd ? 7'h00 : s_ff.winErr + {6'h00, chkErr};
      end
      if (winEnd)
         nxt_s.seqSync = (s_ff.winErr + {6'h00, chkErr}) <= plm_pkg::SYNC_MAX_ERRORS;
      nxt_s.errorPulse = chkErr && s_ff.errControl[1:0] == plm_pkg::ERR_SEL_SEQUENCE;

      // Loop code detection: hits per 64-bit block tolerate stray errors and framing bits
      if (rxSrcTick)
      begin
         nxt_s.rxHist = {s_ff.rxHist[6:0], rxSrcBit};
         nxt_s.codeBits = s_ff.codeBits + 6'h01;
      end
      match[0] = codeMatch(nxt_s.rxHist, s_ff.actCode, s_ff.codeLengths[3:2]);
      match[1] = codeMatch(nxt_s.rxHist, s_ff.deactCode, s_ff.codeLengths[5:4]);
      for (int c = 0; c < 2; c++)
      begin
         if (rxSrcTick)
         begin
            if (s_ff.codeBits == plm_pkg::WINDOW_LAST)
            begin
               nxt_s.present[c] = (s_ff.hits[c] + {6'h00, match[c]}) >= plm_pkg::CODE_MIN_HITS;
               nxt_s.hits[c] = 7'h00;
            end
            else
               nxt_s.hits[c] = s_ff.hits[c] + {6'h00, match[c]};
         end
         if (!s_ff.present[c])
            nxt_s.timer[c] = 30'h00000000;
         else if (s_ff.timer[c] < autoCycles)
            nxt_s.timer[c] = s_ff.timer[c] + 30'h00000001;
         nxt_s.seen[c] = s_ff.present[c] && s_ff.timer[c] >= persistCycles;
         longDone[c] = s_ff.present[c] && s_ff.timer[c] >= autoCycles;
      end

      // Automatic remote loopback
      if (!s_ff.loopControl[plm_pkg::POS_AUTO_REMOTE_LOOP])
         nxt_s.autoRemote = 1'b0;
      else if (longDone[1])
         nxt_s.autoRemote = 1'b0;
      else if (longDone[0])
         nxt_s.autoRemote = 1'b1;

      // Sticky flags: a set in the read cycle survives the clear
      status = {nxt_s.seen[1], nxt_s.seen[0], nxt_s.seqSync};
      prevStatus = {s_ff.seen[1], s_ff.seen[0], s_ff.seqSync};
      for (int b = 0; b < 3; b++)
         evt[b] = s_ff.edgeSel[b] ? (status[b] != prevStatus[b])
                  : (status[b] && !prevStatus[b]);

      // APB: access phase two cycles, pready from a flop
      regIdx = req.addr[7:2];
      accDone = req.sel && req.enable && s_ff.ready;
      rdFlags = accDone && !req.write && regIdx == plm_pkg::IDX_INTERRUPT_FLAGS_A && req.addr[1:0] == 2'h0;
      // Clear only what the read reported, so a set in the answer cycle is kept
      nxt_s.irqFlags = (rdFlags ? s_ff.irqFlags & ~s_ff.rdata[2:0] : s_ff.irqFlags) | evt;
      nxt_s.ready = req.sel && req.enable && !s_ff.ready;
      nxt_s.slvErr = 1'b0;
      nxt_s.rdata = 8'h00;
      if (req.sel && req.enable && !s_ff.ready)
      begin
         nxt_s.slvErr = req.addr[1:0] != 2'h0;
         case (regIdx)
            plm_pkg::IDX_PATTERN_CONTROL: nxt_s.rdata = s_ff.patternControl;
            plm_pkg::IDX_LOOPBACK_CONTROL: nxt_s.rdata = s_ff.loopControl;
            plm_pkg::IDX_LOOP_CODE_LENGTHS: nxt_s.rdata = s_ff.codeLengths;
            plm_pkg::IDX_TX_LOOP_CODE: nxt_s.rdata = s_ff.txCode;
            plm_pkg::IDX_RX_ACTIVATE_CODE: nxt_s.rdata = s_ff.actCode;
            plm_pkg::IDX_RX_DEACTIVATE_CODE: nxt_s.rdata = s_ff.deactCode;
            plm_pkg::IDX_ERROR_COUNT_CONTROL: nxt_s.rdata = s_ff.errControl;
            plm_pkg::IDX_INTERRUPT_MASK_A: nxt_s.rdata = s_ff.irqMask;
            plm_pkg::IDX_INTERRUPT_EDGE_SELECT: nxt_s.rdata = s_ff.edgeSel;
            plm_pkg::IDX_LINE_STATUS_A: nxt_s.rdata = {5'h00, s_ff.seen, s_ff.seqSync};
            plm_pkg::IDX_LINE_STATUS_B: nxt_s.rdata = {7'h00, s_ff.remoteLoop};
            plm_pkg::IDX_INTERRUPT_FLAGS_A: nxt_s.rdata = {5'h00, s_ff.irqFlags};
            plm_pkg::IDX_LINE_MODE: nxt_s.rdata = s_ff.lineMode;
            default: nxt_s.slvErr = 1'b1;
         endcase
      end
      else
      begin
         nxt_s.rdata = s_ff.rdata;
      end
      if (accDone && req.write && !s_ff.slvErr)
      begin
         case (regIdx)
            plm_pkg::IDX_PATTERN_CONTROL: nxt_s.patternControl = req.wdata[7:0];
            plm_pkg::IDX_LOOPBACK_CONTROL: nxt_s.loopControl = req.wdata[7:0];
            plm_pkg::IDX_LOOP_CODE_LENGTHS: nxt_s.codeLengths = req.wdata[7:0];
            plm_pkg::IDX_TX_LOOP_CODE: nxt_s.txCode = req.wdata[7:0];
            plm_pkg::IDX_RX_ACTIVATE_CODE: nxt_s.actCode = req.wdata[7:0];
            plm_pkg::IDX_RX_DEACTIVATE_CODE: nxt_s.deactCode = req.wdata[7:0];
            plm_pkg::IDX_ERROR_COUNT_CONTROL: nxt_s.errControl = req.wdata[7:0];
            plm_pkg::IDX_INTERRUPT_MASK_A: nxt_s.irqMask = req.wdata[7:0];
            plm_pkg::IDX_INTERRUPT_EDGE_SELECT: nxt_s.edgeSel = req.wdata[7:0];
            plm_pkg::IDX_LINE_MODE: nxt_s.lineMode = req.wdata[7:0];
            default: nxt_s.lineMode = s_ff.lineMode;
         endcase
      end
      nxt_s.irq = |(nxt_s.irqFlags & nxt_s.irqMask[2:0]);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         s_ff <= '0;
         s_ff.seqGen <= plm_pkg::SEQ_SEED;
      end
      else
         s_ff <= nxt_s;
   end

   assign prdata = {24'h000000, s_ff.rdata};
   assign pready = s_ff.ready;
   assign pslverr = s_ff.slvErr;
   assign txLineBit = s_ff.txBit;
   assign txLineValid = s_ff.txValid;
   assign rxDataOut = s_ff.rxBit;
   assign rxDataValid = s_ff.rxValid;
   assign analogLoopActive = s_ff.analogLoop;
   assign digitalLoopActive = s_ff.digitalLoop;
   assign remoteLoopActive = s_ff.remoteLoop;
   assign sequenceErrorPulse = s_ff.errorPulse;
   assign interruptOut = s_ff.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence sWinGood;
      winEnd && (s_ff.winErr + {6'h00, chkErr}) <= plm_pkg::SYNC_MAX_ERRORS;
   endsequence
   sequence sWinBad;
      winEnd && (s_ff.winErr + {6'h00, chkErr}) > plm_pkg::SYNC_MAX_ERRORS;
   endsequence

   a_sync_gain: assert property (sWinGood |=> s_ff.seqSync) else $error("sync not set after good window");
   a_sync_loss: assert property (sWinBad |=> !s_ff.seqSync) else $error("sync kept after bad window");
   a_seq_tx_bit: assert property (!remoteNow && patTick && pattSel == plm_pkg::PATT_SEQUENCE
      |=> txLineValid && txLineBit == $past(genOut ^ invert)) else $error("sequence bit wrong");
   a_irq_gate: assert property (interruptOut == |(s_ff.irqFlags & s_ff.irqMask[2:0]))
      else $error("interrupt does not follow flags and mask");
   a_err_feed: assert property (chkErr && s_ff.errControl[1:0] == plm_pkg::ERR_SEL_SEQUENCE
      |=> sequenceErrorPulse) else $error("error not forwarded");
   a_err_quiet: assert property (s_ff.errControl[1:0] != plm_pkg::ERR_SEL_SEQUENCE |=> !sequenceErrorPulse)
      else $error("error forwarded while deselected");
   a_flag_clear: assert property (rdFlags && evt == 3'h0 |=> (s_ff.irqFlags & s_ff.rdata[2:0]) == 3'h0)
      else $error("flag not cleared by read");
   a_auto_remote_loop_enable_release: assert property (!s_ff.loopControl[plm_pkg::POS_AUTO_REMOTE_LOOP] |=> !s_ff.autoRemote)
      else $error("auto loop held without enable");
   a_hw_remote: assert property (s_ff.pinSync[4] && s_ff.pinSync[1:0] == plm_pkg::LOOP_PINS_REMOTE
      |=> remoteLoopActive) else $error("pin remote loop missing");
   a_local_loop: assert property (loopLocal && !remoteNow |=> rxDataValid == txLineValid && rxDataOut == txLineBit)
      else $error("local loop path broken");
   a_code_stop: assert property (!pattClkSel && pattSel == plm_pkg::PATT_NORMAL && !remoteNow
      |=> txLineValid == $past(transmitClockTick) && txLineBit == $past(txDataIn))
      else $error("pattern still sent in normal mode");

endmodule : plm_maint

// File: testbench/plm_far_end.sv
/*
   Far-end line terminal model: sends a repeating loop code, or a changing idle pattern.
   Assumes the block's receive bits and ticks share its system clock.
*/
`timescale 1ns/1ns
module plm_far_end (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Code request from the bench
   input wire logic codeOn,
   input wire logic [7:0] code,
   input wire logic [3:0] codeLen,
   // Line towards the block
   output logic rxLineBit,
   output logic rxLineTick
);
   logic [2:0] bitIdx_ff;
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         bitIdx_ff <= 3'h0;
         rxLineTick <= 1'b0;
         rxLineBit <= 1'b0;
      end
      else
      begin
         rxLineTick <= 1'b1;
         bitIdx_ff <= (bitIdx_ff == 3'h0) ? 3'(codeLen - 4'h1) : bitIdx_ff - 3'h1;
         // Idle flips each bit so a stale level never looks valid
         rxLineBit <= codeOn ? code[bitIdx_ff] : ~rxLineBit;
      end
   end
endmodule : plm_far_end

// File: testbench/pseudo_random_sequence_loopback_maintenance_tb.sv
/*
   Self-checking bench for the maintenance block over APB.
   Assumes shortened persistence and auto-loop counts given as parameters.
*/
`timescale 1ns/1ns
module pseudo_random_sequence_loopback_maintenance_tb;
   logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, txDataIn = 0, codeOn = 0, err;
   logic hwMode = 0, mTick = 0;
   logic [1:0] loopPins = 2'h0;
   logic [3:0] codeLen = 4'h5;
   logic [7:0] paddr = 8'h00, code = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, txLineBit, txLineValid, rxLineBit, rxLineTick, rxDataOut, rxDataValid;
   logic aLoop, dLoop, rLoop, errPulse, irq;
   int bad_count = 0, n_compared = 0, cyc = 0;
   always #5 clock = ~clock;
   plm_far_end farEnd (.clock(clock), .rstn(rstn), .codeOn(codeOn), .code(code), .codeLen(codeLen),
      .rxLineBit(rxLineBit), .rxLineTick(rxLineTick));
   plm_maint #(.PERSIST_E1_CYCLES(200), .PERSIST_T1_CYCLES(300), .AUTO_LOOP_CYCLES(2000)) dut (
      .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hardwareMode(hwMode),
      .patternSelectPins(2'h0), .loopSelectPins(loopPins), .transmitClockTick(1'b1),
      .masterClockTick(mTick), .txDataIn(txDataIn), .txLineBit(txLineBit), .txLineValid(txLineValid),
      .rxLineBit(rxLineBit), .rxLineTick(rxLineTick), .rxDataOut(rxDataOut), .rxDataValid(rxDataValid),
      .analogLoopActive(aLoop), .digitalLoopActive(dLoop), .remoteLoopActive(rLoop),
      .sequenceErrorPulse(errPulse), .interruptOut(irq));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : check
   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_regs();
      apb(1, plm_pkg::IDX_TX_LOOP_CODE, 8'ha5);
      apb(0, plm_pkg::IDX_TX_LOOP_CODE, 8'h00);
      check(rd === 32'h000000a5, "code register readback");
      apb(0, 6'h15, 8'h00);
      check(err === 1'b1 && rd === 32'h0, "unmapped read");
   endtask : test_regs
   task automatic test_pins();
      hwMode <= 1'b1;
      loopPins <= plm_pkg::LOOP_PINS_REMOTE;
      repeat (6) @(posedge clock);
      check(rLoop === 1'b1 && dLoop === 1'b0, "pin remote loop");
      loopPins <= plm_pkg::LOOP_PINS_DIGITAL;
      repeat (6) @(posedge clock);
      check(dLoop === 1'b1 && rLoop === 1'b0, "pin digital loop");
      hwMode <= 1'b0;
      loopPins <= 2'h0;
      repeat (6) @(posedge clock);
   endtask : test_pins
   task automatic test_sequence();
      int ones, miss, vals;
      ones = 0;
      miss = 0;
      vals = 0;
      apb(1, plm_pkg::IDX_INTERRUPT_MASK_A, 8'h01);
      apb(1, plm_pkg::IDX_LOOPBACK_CONTROL, 8'h02);
      apb(1, plm_pkg::IDX_PATTERN_CONTROL, {6'h1, plm_pkg::PATT_SEQUENCE});
      repeat (500)
      begin
         @(posedge clock);
         ones += (txLineBit === 1'b1);
         vals += (txLineValid === 1'b1);
         miss += (rxDataValid === 1'b1 && rxDataOut !== txLineBit);
      end
      check(ones > 20, "no sequence on line");
      check(vals > 200 && vals < 300, "master tick paces pattern");
      check(miss == 0 && dLoop === 1'b1, "digital loop echo");
      apb(0, plm_pkg::IDX_LINE_STATUS_A, 8'h00);
      check(rd[0] === 1'b1, "sequence sync");
      check(irq === 1'b1, "sync interrupt");
      apb(0, plm_pkg::IDX_INTERRUPT_FLAGS_A, 8'h00);
      check(rd[0] === 1'b1, "sync flag");
      repeat (3) @(posedge clock);
      check(irq === 1'b0, "flag clear on read");
   endtask : test_sequence
   task automatic test_remote();
      int ones;
      ones = 0;
      apb(1, plm_pkg::IDX_PATTERN_CONTROL, 8'h00);
      apb(1, plm_pkg::IDX_LOOPBACK_CONTROL, 8'h04);
      repeat (100)
      begin
         @(posedge clock);
         ones += (txLineBit === 1'b1);
      end
      check(ones > 20 && rLoop === 1'b1, "remote loop to line");
      apb(1, plm_pkg::IDX_LOOPBACK_CONTROL, 8'h00);
   endtask : test_remote
   task automatic test_code();
      apb(1, plm_pkg::IDX_LINE_MODE, 8'h01);
      apb(1, plm_pkg::IDX_LOOP_CODE_LENGTHS, 8'h10);
      apb(1, plm_pkg::IDX_RX_ACTIVATE_CODE, 8'h15);
      apb(1, plm_pkg::IDX_RX_DEACTIVATE_CODE, 8'h38);
      apb(1, plm_pkg::IDX_LOOPBACK_CONTROL, 8'h08);
      code <= 8'h15;
      codeOn <= 1'b1;
      repeat (600) @(posedge clock);
      apb(0, plm_pkg::IDX_LINE_STATUS_A, 8'h00);
      check(rd[1] === 1'b1, "activate seen");
      repeat (2200) @(posedge clock);
      check(rLoop === 1'b1, "auto loop set");
      codeOn <= 1'b0;
      repeat (200) @(posedge clock);
      check(rLoop === 1'b1, "auto loop held");
      code <= 8'h38;
      codeLen <= 4'h6;
      codeOn <= 1'b1;
      repeat (2400) @(posedge clock);
      apb(0, plm_pkg::IDX_LINE_STATUS_A, 8'h00);
      check(rLoop === 1'b0 && rd[2] === 1'b1, "deactivate releases loop");
      code <= 8'h15;
      codeLen <= 4'h5;
      repeat (2400) @(posedge clock);
      check(rLoop === 1'b1, "auto loop set again");
      apb(1, plm_pkg::IDX_LOOPBACK_CONTROL, 8'h00);
      repeat (3) @(posedge clock);
      check(rLoop === 1'b0, "forced release");
   endtask : test_code
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      mTick <= ~mTick;
      if (cyc == 20000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      test_regs();
      test_pins();
      test_sequence();
      test_remote();
      test_code();
      give_verdict();
   end
endmodule : pseudo_random_sequence_loopback_maintenance_tb
